// ===== rsts_params.svh
// Constants for the receiver self-test sequencer.
// Assumes a 40 MHz mclk; transmit, minimum on and response times are in ms and converted to cycles here.
`ifndef RSTS_PARAMS_SVH
`define RSTS_PARAMS_SVH
`define RSTS_CLK_HZ 40000000
`define RSTS_TX_MS 5000
`define RSTS_MIN_ON_MS 25
`define RSTS_RESP_MS 20
`define RSTS_TX_CYC ((`RSTS_CLK_HZ / 1000) * `RSTS_TX_MS)
`define RSTS_MIN_ON_CYC ((`RSTS_CLK_HZ / 1000) * `RSTS_MIN_ON_MS)
`define RSTS_RESP_CYC ((`RSTS_CLK_HZ / 1000) * `RSTS_RESP_MS)
`define RSTS_FLASH_CYC 4000000
`define RSTS_STEP1_REPS 2
`define RSTS_STEP2_REPS 5
`define RSTS_LED_HALF 2000000
`define RSTS_STRAP_CYC 4
`endif

// ===== rsts_pkg.sv
// Types for the receiver self-test sequencer.
// Assumes rsts_params.svh supplies the numbers.
package rsts_pkg;
  typedef enum logic [2:0] {
    RSTS_IDLE = 3'b000,
    RSTS_WALK = 3'b001,
    RSTS_PAIR = 3'b011,
    RSTS_TX = 3'b010,
    RSTS_RSSI = 3'b110,
    RSTS_NORM = 3'b111
  } rsts_state_t;

  typedef struct packed {
    logic [3:0] outs;
    logic tx_en;
    logic led;
  } rsts_drive_t;
endpackage : rsts_pkg

// ===== rsts_seq.sv
// Self-test sequencer and output on-time guard for the receiver.
// Assumes normal-mode requests and signal strength arrive on mclk; learn pin is asynchronous.
`timescale 1ns/1ps
`include "rsts_params.svh"
module rsts_seq import rsts_pkg::*; #(
  parameter int TX_CYC = `RSTS_TX_CYC,
  parameter int FLASH_CYC = `RSTS_FLASH_CYC,
  parameter int MIN_ON_CYC = `RSTS_MIN_ON_CYC,
  parameter int LED_HALF = `RSTS_LED_HALF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Learn pin, three signals
  input wire logic learn_pin_in,
  output logic learn_pin_out,
  output logic learn_pin_oe,
  // Normal operation and radio
  input wire logic [3:0] norm_req,
  input wire logic [2:0] rssi_level,
  input wire logic rssi_valid,
  // Outputs
  output logic [3:0] switched_outputs,
  output logic tx_full_power,
  output logic self_test_active
);
  logic [2:0] lp_sync_r;
  logic learn_lvl_r;
  logic [2:0] strap_cnt_r;
  logic [31:0] on_cnt_r;
  rsts_state_t state_r;
  logic [31:0] tick_r;
  logic [3:0] idx_r;
  logic [3:0] reps_r;
  logic phase_r;
  logic [31:0] led_cnt_r;
  logic led_blink_r;
  logic [3:0] want;
  logic [3:0] out_r;
  logic [31:0] hold_r [4];
  logic tick_end;
  rsts_drive_t drv;

  // Bar graph level to thermometer code
  function automatic logic [3:0] bar_of(input logic [2:0] lvl);
    bar_of = (lvl >= 3'h4) ? 4'hF : (lvl == 3'h3) ? 4'h7 : (lvl == 3'h2) ? 4'h3 : (lvl == 3'h1) ? 4'h1 : 4'h0;
  endfunction : bar_of

  // Synchroniser; change counts when stages two and three agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lp_sync_r <= 3'h7;
      learn_lvl_r <= 1'b1;
    end else if (ce) begin
      lp_sync_r <= {lp_sync_r[1:0], learn_pin_in};
      if (lp_sync_r[1] == lp_sync_r[2]) learn_lvl_r <= lp_sync_r[2];
    end
  end

  assign tick_end = (tick_r == 32'(FLASH_CYC - 1));

  // State sequencing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= RSTS_IDLE;
      strap_cnt_r <= 3'h0;
      tick_r <= 32'h0;
      idx_r <= 4'h0;
      reps_r <= 4'h0;
      phase_r <= 1'b0;
    end else if (ce) begin
      unique case (state_r)
        RSTS_IDLE: begin
          // Reset level of the chain reads as released; wait until the pin level is through
          if (strap_cnt_r == 3'(`RSTS_STRAP_CYC)) begin
            state_r <= learn_lvl_r ? RSTS_NORM : RSTS_WALK;
          end else strap_cnt_r <= strap_cnt_r + 3'h1;
        end
        RSTS_WALK, RSTS_PAIR: begin
          tick_r <= tick_end ? 32'h0 : tick_r + 32'h1;
          if (tick_end) begin
            phase_r <= ~phase_r;
            if (phase_r) begin
              if (state_r == RSTS_WALK) begin
                if (reps_r == 4'(`RSTS_STEP1_REPS - 1)) begin
                  reps_r <= 4'h0;
                  if (idx_r == 4'h3) begin
                    idx_r <= 4'h0;
                    state_r <= RSTS_PAIR;
                  end else idx_r <= idx_r + 4'h1;
                end else reps_r <= reps_r + 4'h1;
              end else begin
                if (reps_r == 4'(`RSTS_STEP2_REPS - 1)) begin
                  reps_r <= 4'h0;
                  if (idx_r == 4'h1) begin
                    idx_r <= 4'h0;
                    state_r <= RSTS_TX;
                  end else idx_r <= 4'h1;
                end else reps_r <= reps_r + 4'h1;
              end
            end
          end
        end
        RSTS_TX: begin
          tick_r <= tick_r + 32'h1;
          if (tick_r == 32'(TX_CYC - 1)) begin
            tick_r <= 32'h0;
            state_r <= RSTS_RSSI;
          end
        end
        RSTS_RSSI: state_r <= RSTS_RSSI;
        RSTS_NORM: state_r <= RSTS_NORM;
        default: state_r <= RSTS_IDLE;
      endcase
    end
  end

  // LED blink during transmit step
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      led_cnt_r <= 32'h0;
      led_blink_r <= 1'b0;
    end else if (ce) begin
      if (state_r != RSTS_TX) begin
        led_cnt_r <= 32'h0;
        led_blink_r <= 1'b0;
      end else if (led_cnt_r == 32'(LED_HALF - 1)) begin
        led_cnt_r <= 32'h0;
        led_blink_r <= ~led_blink_r;
      end else led_cnt_r <= led_cnt_r + 32'h1;
    end
  end

  // Requested outputs per state
  assign want = (state_r == RSTS_WALK) ? (phase_r ? 4'h0 : 4'(4'h1 << idx_r[1:0])) :
                (state_r == RSTS_PAIR) ? (phase_r ? 4'h0 : (idx_r[0] ? 4'hA : 4'h5)) :
                (state_r == RSTS_RSSI) ? (rssi_valid ? bar_of(rssi_level) : 4'h0) :
                (state_r == RSTS_NORM) ? norm_req : 4'h0;

  // Minimum on-time guard; turn-on takes effect on the next edge
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_hold
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          out_r[g] <= 1'b0;
          hold_r[g] <= 32'h0;
        end else if (ce) begin
          if (want[g] && !out_r[g]) begin
            out_r[g] <= 1'b1;
            hold_r[g] <= 32'(MIN_ON_CYC - 1);
          end else if (hold_r[g] != 32'h0) hold_r[g] <= hold_r[g] - 32'h1;
          else out_r[g] <= want[g];
        end
      end
    end
  endgenerate

  assign drv.outs = out_r;
  assign drv.tx_en = (state_r == RSTS_TX);
  assign drv.led = led_blink_r;

  // Registered pin drivers; LED lit by pulling the pin low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      switched_outputs <= 4'h0;
      tx_full_power <= 1'b0;
      learn_pin_out <= 1'b0;
      learn_pin_oe <= 1'b0;
      self_test_active <= 1'b0;
    end else if (ce) begin
      switched_outputs <= drv.outs;
      tx_full_power <= drv.tx_en;
      learn_pin_out <= 1'b0;
      learn_pin_oe <= drv.led;
      self_test_active <= (state_r != RSTS_IDLE) && (state_r != RSTS_NORM);
    end
  end

  // Own on-time count of output one; saturates so a long display never wraps
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      on_cnt_r <= 32'h0;
    end else if (ce) begin
      if (!switched_outputs[0]) on_cnt_r <= 32'h0;
      else if (on_cnt_r != 32'hFFFFFFFF) on_cnt_r <= on_cnt_r + 32'h1;
    end
  end

  sequence walk_enter_s;
    (state_r == RSTS_WALK) && (reps_r == 4'h0) && (idx_r == 4'h0);
  endsequence

  strap_low_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RSTS_IDLE) ##1 walk_enter_s |-> !$past(learn_lvl_r))
    else $error("self-test entered with learn released");
  strap_high_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RSTS_IDLE) ##1 (state_r == RSTS_NORM) |-> $past(learn_lvl_r))
    else $error("normal mode entered with learn held");
  walk_one_hot_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == RSTS_WALK |-> $countones(want) <= 1)
    else $error("walk drives more than one output");
  pair_mask_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == RSTS_PAIR |-> (want == 4'h0 || want == 4'h5 || want == 4'hA))
    else $error("pair step drives wrong outputs");
  tx_only_a: assert property (@(posedge mclk) disable iff (rst)
    ce && tx_full_power |-> $past(state_r) == RSTS_TX)
    else $error("transmitter keyed outside transmit step");
  bar_graph_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == RSTS_RSSI && rssi_valid && rssi_level >= 3'h4 |-> want == 4'hF)
    else $error("maximum strength not shown as four outputs");
  rssi_hold_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == RSTS_RSSI |=> state_r == RSTS_RSSI)
    else $error("display state left without reset");
  norm_resp_a: assert property (@(posedge mclk) disable iff (rst)
    ce && state_r == RSTS_NORM && norm_req[0] && !out_r[0] |=> out_r[0])
    else $error("output not activated promptly");
  min_on_a: assert property (@(posedge mclk) disable iff (rst)
    ce && $rose(out_r[0]) |-> hold_r[0] == 32'(MIN_ON_CYC - 1))
    else $error("minimum on-time not loaded");
  min_on_time_a: assert property (@(posedge mclk) disable iff (rst)
    ce && switched_outputs[0] && !out_r[0] |-> on_cnt_r >= 32'(MIN_ON_CYC - 1))
    else $error("output one released before minimum on-time");
  led_pin_a: assert property (@(posedge mclk) disable iff (rst)
    learn_pin_oe |-> !learn_pin_out)
    else $error("learn LED not driven low");
endmodule : rsts_seq

// ===== rsts_learn_model.sv
// Learn button and learn LED sharing the open-drain learn pin.
// Assumes a pull-up on the pin; the button grounds it when pressed.
`timescale 1ns/1ps
module rsts_learn_model (
  // Button
  input wire logic press,
  // Pin drive from the sequencer
  input wire logic learn_pin_out,
  input wire logic learn_pin_oe,
  // Resolved pin level and LED state
  output logic learn_pin_in,
  output logic led_lit
);
  // Pull-up wins only while nobody grounds the pin
  assign learn_pin_in = !(press || (learn_pin_oe && !learn_pin_out));
  assign led_lit = learn_pin_oe && !learn_pin_out;
endmodule : rsts_learn_model

// ===== receiver_self_test_sequencer_test.sv
// Self-checking bench for the receiver self-test sequencer.
// Assumes short tick parameters so a whole self-test stays brief.
`timescale 1ns/1ps
module receiver_self_test_sequencer_test;
  import rsts_pkg::*;
  localparam int TXC = 200;
  localparam int MON = 10;
  logic mclk, rst, ce, press, pin_in, pin_out, pin_oe, rssi_valid, tx_on, st_on, led;
  logic [3:0] norm_req, outs, prev_o;
  logic [2:0] rssi_level;
  logic [3:0] log_q[$];
  int err_count, compares;
  rsts_seq #(.TX_CYC(TXC), .FLASH_CYC(40), .MIN_ON_CYC(MON), .LED_HALF(8)) DUT (.mclk(mclk), .rst(rst),
    .ce(ce), .learn_pin_in(pin_in), .learn_pin_out(pin_out), .learn_pin_oe(pin_oe), .norm_req(norm_req),
    .rssi_level(rssi_level), .rssi_valid(rssi_valid), .switched_outputs(outs), .tx_full_power(tx_on),
    .self_test_active(st_on));
  rsts_learn_model PART (.press(press), .learn_pin_out(pin_out), .learn_pin_oe(pin_oe),
    .learn_pin_in(pin_in), .led_lit(led));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Log every change of the outputs so flash order can be judged later
  always @(posedge mclk) begin
    if (rst) prev_o <= 4'h0;
    else if (outs !== prev_o) begin
      log_q.push_back(outs);
      prev_o <= outs;
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic wait_tx(logic v, int lim);
    int n;
    n = 0;
    while (tx_on !== v) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        err_count++;
        $display("MISMATCH tx_full_power expected %0d seen timeout", v);
        conclude();
      end
    end
  endtask : wait_tx
  // Button held through reset and a few edges after, as the strap needs
  task automatic do_reset(logic hold);
    press = hold;
    rst = 1'b1;
    log_q.delete();
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    press = 1'b0;
  endtask : do_reset
  task automatic t_normal;
    int n;
    do_reset(1'b0);
    check("self_test_active", 0, st_on);
    norm_req = 4'h3;
    @(negedge mclk);
    norm_req = 4'h0;
    n = 0;
    while (outs !== 4'h3 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    check("outputs on", 4'h3, outs);
    n = 0;
    while (outs === 4'h3 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check("min on time", 1, n >= MON - 1);
    check("outputs off", 4'h0, outs);
    $display("test normal done");
  endtask : t_normal
  task automatic t_selftest;
    logic [3:0] exp_q[$];
    int n, lit;
    do_reset(1'b1);
    for (int i = 0; i < 4; i++) begin
      repeat (2) begin
        exp_q.push_back(4'h1 << i);
        exp_q.push_back(4'h0);
      end
    end
    for (int i = 0; i < 10; i++) begin
      exp_q.push_back(i < 5 ? 4'h5 : 4'hA);
      exp_q.push_back(4'h0);
    end
    wait_tx(1'b1, 3000);
    check("self_test_active", 1, st_on);
    check("pattern count", exp_q.size(), log_q.size());
    foreach (exp_q[i]) check("pattern", exp_q[i], i < log_q.size() ? log_q[i] : 4'hX);
    n = 0;
    lit = 0;
    while (tx_on === 1'b1 && n < TXC + 50) begin
      if (led) check("pin low while lit", 0, pin_in);
      lit += led;
      @(negedge mclk);
      n++;
    end
    check("tx length", 1, n >= TXC - 2 && n <= TXC + 2);
    check("led flashing", 1, lit > TXC / 4 && lit < 3 * TXC / 4);
    rssi_valid = 1'b1;
    // Rising levels only, so the min-on guard never delays a change
    for (int l = 0; l < 8; l++) begin
      rssi_level = l[2:0];
      repeat (MON + 4) @(negedge mclk);
      check("bar graph", l >= 4 ? 4'hF : (4'h1 << l) - 4'h1, outs);
    end
    // Enable low must freeze the full bar although the signal goes away
    ce = 1'b0;
    rssi_valid = 1'b0;
    repeat (MON + 4) @(negedge mclk);
    check("frozen bar", 4'hF, outs);
    ce = 1'b1;
    repeat (MON + 4) @(negedge mclk);
    check("bar invalid", 4'h0, outs);
    press = 1'b1;
    repeat (300) @(negedge mclk);
    press = 1'b0;
    check("display held", 1, st_on === 1'b1 && tx_on === 1'b0);
    $display("test self-test done");
  endtask : t_selftest
  initial begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    ce = 1'b1;
    press = 1'b0;
    norm_req = 4'h0;
    rssi_level = 3'h0;
    rssi_valid = 1'b0;
    @(negedge mclk);
    t_normal();
    t_selftest();
    conclude();
  end
endmodule : receiver_self_test_sequencer_test
